// *** shared/bpa_pkg.sv ***
// Shared constants, encodings and helpers for the backplane bus arbiter node.
// Assumes one 125 MHz core clock from which the bus cycle is derived.
package bpa_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   // Core clock period in nanoseconds.
   localparam int CLK_PERIOD_NS = 8;
   // One bus cycle in nanoseconds.
   localparam int BUS_CYCLE_NS = 200;
   // Core clocks per bus cycle, rounded up, never below one.
   localparam int CYC_CLKS_RAW = (BUS_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_CLKS = (CYC_CLKS_RAW < 1) ? 1 : CYC_CLKS_RAW;
   // Width of the cycle divider counter.
   localparam int CYC_CNT_W = 5;

   // ----------------------------------------
   // Widths and sizes
   // ----------------------------------------
   // Number of request lines on the backplane.
   localparam int NODES = 16;
   // Physical address width, one gigabyte.
   localparam int ADDR_W = 30;
   // Data path width.
   localparam int DATA_W = 32;
   // History depth and index width.
   localparam int HIST_DEPTH = 16;
   localparam int HIST_AW = 4;
   // History entry: error, confirmation, hold, tag, data.
   localparam int HIST_W = 38;

   // ----------------------------------------
   // Bus encodings and field positions
   // ----------------------------------------
   // Cycle tags carried on the control lines.
   localparam logic [1:0] TAG_IDLE = 2'h0;
   localparam logic [1:0] TAG_ADDR = 2'h1;
   localparam logic [1:0] TAG_DATA = 2'h2;
   // Confirmation codes returned by the receiver.
   localparam logic [1:0] CNF_NONE = 2'h0;
   localparam logic [1:0] CNF_ACK = 2'h1;
   localparam logic [1:0] CNF_NAK = 2'h2;
   // Address word: double flag, write flag, 30-bit address.
   localparam int AW_DBL_BIT = 31;
   localparam int AW_WR_BIT = 30;
   // Address bit that selects the I/O half of the space.
   localparam int IO_BIT = 29;
   // Reset value of a driven bus word.
   localparam logic [31:0] WORD_RST = 32'h0;

   // Sender state machine.
   typedef enum logic [2:0] {TX_IDLE, TX_ARB, TX_ADDR, TX_DATA0, TX_DATA1, TX_CONF} bpa_tx_t;

   // Even parity over a data word.
   function automatic logic bpa_par32(input logic [31:0] w);
      return ^w;
   endfunction : bpa_par32

   // Even parity over the control lines.
   function automatic logic bpa_ctl_par(input logic [1:0] tag, input logic hold);
      return ^{tag, hold};
   endfunction : bpa_ctl_par

endpackage : bpa_pkg

// *** hdl/bpa_cycle_div.sv ***
// Bus cycle divider: one-cycle enable at the end of every bus cycle.
// Assumes a synchronous active-high reset on the core clock.
`timescale 1ns/1ps
`default_nettype none
module bpa_cycle_div import bpa_pkg::*; (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic sys_rst,
   // End-of-cycle enable.
   output logic cyc_en
);
   // Divider state.
   typedef struct packed {
      logic [CYC_CNT_W-1:0] cnt; // Clocks elapsed in this bus cycle.
   } bpa_div_st_t;

   localparam logic [CYC_CNT_W-1:0] CNT_LAST = CYC_CNT_W'(CYC_CLKS - 1);

   bpa_div_st_t st;
   bpa_div_st_t next_st;

   // ----------------------------------------
   // Counter
   // ----------------------------------------
   // Wraps after the last clock of a bus cycle.
   always_comb begin
      next_st = st;
      if (st.cnt == CNT_LAST) begin
         next_st.cnt = '0;
      end else begin
         next_st.cnt = st.cnt + CYC_CNT_W'(1);
      end
   end

   // Registers the state; reset restarts the cycle.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // The enable marks the last clock of the bus cycle.
   assign cyc_en = (st.cnt == CNT_LAST);

endmodule : bpa_cycle_div
`default_nettype wire

// *** hdl/bpa_history.sv ***
// Circular record of the most recent bus cycles, read back by age.
// Assumes the caller strobes rec once per bus cycle.
`timescale 1ns/1ps
`default_nettype none
module bpa_history import bpa_pkg::*; (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic sys_rst,
   // Recording side.
   input wire logic rec,
   input wire logic [HIST_W-1:0] rec_entry,
   // Read side; index 0 is the newest entry.
   input wire logic [HIST_AW-1:0] rd_idx,
   output logic [HIST_W-1:0] rd_entry,
   output logic hist_full
);
   // Store, write pointer, fill flag and read register.
   typedef struct packed {
      logic [HIST_DEPTH-1:0][HIST_W-1:0] mem;
      logic [HIST_AW-1:0] wptr;
      logic full;
      logic [HIST_W-1:0] rd;
   } bpa_hist_st_t;

   bpa_hist_st_t st;
   bpa_hist_st_t next_st;

   // ----------------------------------------
   // Write and read
   // ----------------------------------------
   // New cycles overwrite the oldest slot once all are filled.
   always_comb begin
      next_st = st;
      for (int i = 0; i < HIST_DEPTH; i++) begin
         if (rec && st.wptr == HIST_AW'(i)) begin
            next_st.mem[i] = rec_entry;
         end
      end
      if (rec) begin
         next_st.wptr = st.wptr + HIST_AW'(1);
         if (st.wptr == HIST_AW'(HIST_DEPTH - 1)) begin
            next_st.full = 1'b1;
         end
      end
      next_st.rd = st.mem[HIST_AW'(st.wptr - HIST_AW'(1) - rd_idx)];
   end

   // Registers the state.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign rd_entry = st.rd;
   assign hist_full = st.full;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_hist_store: assert property (@(posedge core_clk) disable iff (sys_rst)
      rec |=> st.mem[$past(st.wptr)] == $past(rec_entry))
      else $error("history entry not stored");
   a_hist_wrap: assert property (@(posedge core_clk) disable iff (sys_rst)
      (rec && st.wptr == 4'hF) |=> (st.wptr == 4'h0 && st.full))
      else $error("history pointer did not wrap");

endmodule : bpa_history
`default_nettype wire

// *** hdl/bpa_node.sv ***
// Backplane bus node: distributed arbitration, sender, receiver, checker.
// Assumes all bus inputs are synchronous to core_clk and change per bus cycle.
//
// How it works
// - All nodes step on one 200 ns cycle.
// - Physical addresses are 30 bits wide.
// - Lower half memory, upper half I/O.
// - Each node owns one request line, fixed priority.
// - Cycle end: highest requester takes next cycle unless the bus is held.
// - Holder frees the bus as early as possible.
// - Each node decides its own win locally.
// - Control information carries parity, checked everywhere.
// - 32-bit path; one or two word transfers.
// - Every transfer parity checked and confirmed.
// - Protocol checked every cycle, violations flagged.
// - Keep activity of the last 16 cycles.
`timescale 1ns/1ps
`default_nettype none
module bpa_node import bpa_pkg::*; #(
   parameter logic [3:0] NODE_ID = 4'h3,           // Own line; lower line is higher priority.
   parameter logic [29:0] RX_BASE = 30'h3F000000,  // Receive window base.
   parameter logic [29:0] RX_MASK = 30'h3FFFF000   // Receive window compare mask.
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic sys_rst,
   // User send request.
   input wire logic req_valid,
   input wire logic req_double,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [DATA_W-1:0] req_data0,
   input wire logic [DATA_W-1:0] req_data1,
   output logic req_ready,
   // User send result.
   output logic xfer_done,
   output logic xfer_error,
   // Received words.
   output logic rx_valid,
   output logic [ADDR_W-1:0] rx_addr,
   output logic [DATA_W-1:0] rx_data,
   output logic rx_is_io,
   // Arbitration lines.
   input wire logic [NODES-1:0] bus_req_in,
   output logic bus_req_out,
   // Bus transfer lines as seen on the backplane.
   input wire logic [DATA_W-1:0] bus_data_in,
   input wire logic bus_par_in,
   input wire logic [1:0] bus_tag_in,
   input wire logic bus_hold_in,
   input wire logic bus_ctl_par_in,
   // Bus transfer lines as driven by this node.
   output logic [DATA_W-1:0] bus_data_out,
   output logic bus_par_out,
   output logic [1:0] bus_tag_out,
   output logic bus_hold_out,
   output logic bus_ctl_par_out,
   output logic bus_oe,
   // Confirmation lines.
   input wire logic [1:0] bus_cnf_in,
   output logic [1:0] bus_cnf_out,
   output logic bus_cnf_oe,
   // Error flags.
   output logic par_err,
   output logic proto_err,
   // History access.
   input wire logic hist_freeze,
   input wire logic [HIST_AW-1:0] hist_idx,
   output logic [HIST_W-1:0] hist_entry,
   output logic hist_full
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      bpa_tx_t tx;                 // Sender state.
      logic req_line;              // Own request line.
      logic [ADDR_W-1:0] addr;     // Latched send address.
      logic dbl;                   // Latched double-word flag.
      logic [DATA_W-1:0] d0;       // First data word.
      logic [DATA_W-1:0] d1;       // Second data word.
      logic drv_oe;                // Driving the transfer lines.
      logic [DATA_W-1:0] drv_data; // Driven word.
      logic drv_par;               // Parity of the driven word.
      logic [1:0] drv_tag;         // Driven cycle tag.
      logic drv_hold;              // Driven hold, more words follow.
      logic drv_cpar;              // Parity of the driven control lines.
      logic cnf_due;               // A word of ours awaits confirmation.
      logic bad;                   // A confirmation failed.
      logic rx_act;                // Receiving a transaction.
      logic [1:0] rx_left;         // Data words still to receive.
      logic [ADDR_W-1:0] rx_addr;  // Address of the received transaction.
      logic [DATA_W-1:0] rx_data;  // Last received word.
      logic rx_valid;              // Received word strobe.
      logic cnf_oe;                // Driving a confirmation.
      logic [1:0] cnf_val;         // Confirmation code.
      logic prev_hold;             // Hold seen in the last cycle.
      logic done;                  // Send finished strobe.
      logic err;                   // Send failed strobe.
      logic par_err;               // Parity error strobe.
      logic proto_err;             // Protocol error strobe.
   } bpa_node_st_t;

   // Lines below our own have higher priority.
   localparam logic [NODES-1:0] HI_MASK = (16'h1 << NODE_ID) - 16'h1;

   bpa_node_st_t st;
   bpa_node_st_t next_st;
   logic cyc_en;  // Last core clock of a bus cycle.
   logic win;     // No higher request is up.
   logic d_ok;    // Data parity good.
   logic c_ok;    // Control parity good.
   logic hit;     // Address word falls in our window.
   logic cnf_bad; // Awaited confirmation missing or negative.

   // ----------------------------------------
   // Bus cycle
   // ----------------------------------------
   // Every decision below except taking a new send is taken on the last clock of a bus cycle.
   bpa_cycle_div u_div (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .cyc_en(cyc_en)
   );

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   // Local view of arbitration, parity and window match.
   always_comb begin
      win = ~|(bus_req_in & HI_MASK);
      d_ok = bpa_par32(bus_data_in) == bus_par_in;
      c_ok = bpa_ctl_par(bus_tag_in, bus_hold_in) == bus_ctl_par_in;
      hit = (bus_data_in[ADDR_W-1:0] & RX_MASK) == RX_BASE;
      cnf_bad = st.cnf_due && (bus_cnf_in != CNF_ACK);
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      next_st = st;
      next_st.done = 1'b0;
      next_st.err = 1'b0;
      next_st.rx_valid = 1'b0;
      next_st.par_err = 1'b0;
      next_st.proto_err = 1'b0;
      // A new send is taken only while idle.
      if (req_valid && st.tx == TX_IDLE) begin
         next_st.tx = TX_ARB;
         next_st.req_line = 1'b1;
         next_st.addr = req_addr;
         next_st.dbl = req_double;
         next_st.d0 = req_data0;
         next_st.d1 = req_data1;
      end
      if (cyc_en) begin
         // Checker looks at every cycle on the bus.
         next_st.par_err = !c_ok || (bus_tag_in != TAG_IDLE && !d_ok);
         next_st.proto_err = (st.prev_hold && bus_tag_in == TAG_IDLE)
            || (!st.prev_hold && bus_tag_in == TAG_DATA)
            || (bus_tag_in == TAG_IDLE && bus_hold_in);
         next_st.prev_hold = bus_hold_in;
         next_st.cnf_due = st.drv_oe;
         // Sender: the word for the next cycle, released by default.
         next_st.drv_oe = 1'b0;
         next_st.drv_data = WORD_RST;
         next_st.drv_tag = TAG_IDLE;
         next_st.drv_hold = 1'b0;
         case (st.tx)
            TX_ARB: begin
               // A holder keeps the bus; otherwise the highest request wins.
               if (win && !bus_hold_in) begin
                  next_st.tx = TX_ADDR;
                  next_st.req_line = 1'b0;
                  next_st.bad = 1'b0;
                  next_st.drv_oe = 1'b1;
                  next_st.drv_data = {st.dbl, 1'b1, st.addr};
                  next_st.drv_tag = TAG_ADDR;
                  next_st.drv_hold = 1'b1;
               end else begin
                  next_st.req_line = 1'b1;
               end
            end
            TX_ADDR: begin
               // First data word; hold stays up only for a second word.
               next_st.tx = TX_DATA0;
               next_st.drv_oe = 1'b1;
               next_st.drv_data = st.d0;
               next_st.drv_tag = TAG_DATA;
               next_st.drv_hold = st.dbl;
            end
            TX_DATA0: begin
               next_st.bad = st.bad | cnf_bad;
               if (st.dbl) begin
                  next_st.tx = TX_DATA1;
                  next_st.drv_oe = 1'b1;
                  next_st.drv_data = st.d1;
                  next_st.drv_tag = TAG_DATA;
               end else begin
                  next_st.tx = TX_CONF;
               end
            end
            TX_DATA1: begin
               next_st.bad = st.bad | cnf_bad;
               next_st.tx = TX_CONF;
            end
            TX_CONF: begin
               // The last word's confirmation closes the send.
               next_st.tx = TX_IDLE;
               next_st.done = 1'b1;
               next_st.err = st.bad | cnf_bad;
            end
            default: begin
               // Idle: nothing to drive; a request taken on this very clock keeps its arbitration state.
            end
         endcase
         next_st.drv_par = bpa_par32(next_st.drv_data);
         next_st.drv_cpar = bpa_ctl_par(next_st.drv_tag, next_st.drv_hold);
         // Receiver: confirm each word of a transaction in our window.
         next_st.cnf_oe = 1'b0;
         next_st.cnf_val = CNF_NONE;
         if (bus_tag_in == TAG_ADDR && !st.rx_act && hit) begin
            next_st.rx_act = 1'b1;
            next_st.rx_left = bus_data_in[AW_DBL_BIT] ? 2'h2 : 2'h1;
            next_st.rx_addr = bus_data_in[ADDR_W-1:0];
            next_st.cnf_oe = 1'b1;
            next_st.cnf_val = d_ok ? CNF_ACK : CNF_NAK;
         end else if (bus_tag_in == TAG_DATA && st.rx_act) begin
            next_st.rx_valid = 1'b1;
            next_st.rx_data = bus_data_in;
            next_st.rx_left = st.rx_left - 2'h1;
            next_st.rx_act = (st.rx_left != 2'h1);
            next_st.cnf_oe = 1'b1;
            next_st.cnf_val = d_ok ? CNF_ACK : CNF_NAK;
         end else if (st.rx_act) begin
            // A transaction that breaks off is abandoned.
            next_st.rx_act = 1'b0;
         end
      end
   end

   // Registers the state.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign req_ready = (st.tx == TX_IDLE);
   assign xfer_done = st.done;
   assign xfer_error = st.err;
   assign rx_valid = st.rx_valid;
   assign rx_addr = st.rx_addr;
   assign rx_data = st.rx_data;
   assign rx_is_io = st.rx_addr[IO_BIT];
   assign bus_req_out = st.req_line;
   assign bus_data_out = st.drv_data;
   assign bus_par_out = st.drv_par;
   assign bus_tag_out = st.drv_tag;
   assign bus_hold_out = st.drv_hold;
   assign bus_ctl_par_out = st.drv_cpar;
   assign bus_oe = st.drv_oe;
   assign bus_cnf_out = st.cnf_val;
   assign bus_cnf_oe = st.cnf_oe;
   assign par_err = st.par_err;
   assign proto_err = st.proto_err;

   // ----------------------------------------
   // History
   // ----------------------------------------
   // Each bus cycle outside a freeze is recorded with its confirmation and any parity error seen.
   bpa_history u_hist (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .rec(cyc_en && !hist_freeze),
      .rec_entry({!c_ok || (bus_tag_in != TAG_IDLE && !d_ok), bus_cnf_in, bus_hold_in, bus_tag_in, bus_data_in}),
      .rd_idx(hist_idx),
      .rd_entry(hist_entry),
      .hist_full(hist_full)
   );

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   // Clocks since the last bus cycle end.
   logic [CYC_CNT_W-1:0] gap;
   always_ff @(posedge core_clk) begin
      if (sys_rst || cyc_en) begin
         gap <= '0;
      end else begin
         gap <= gap + CYC_CNT_W'(1);
      end
   end

   sequence s_launch;
      cyc_en && st.tx == TX_ARB && win && !bus_hold_in;
   endsequence
   sequence s_addr_word;
      st.tx == TX_ADDR && bus_tag_out == TAG_ADDR && bus_hold_out;
   endsequence

   a_cycle_period: assert property (cyc_en |-> gap == 5'h18)
      else $error("bus cycle length wrong");
   a_addr_word: assert property (s_launch |=> s_addr_word ##0 bus_data_out[29:0] == st.addr)
      else $error("address word not launched");
   a_io_half: assert property (cyc_en && bus_tag_in == TAG_ADDR && !st.rx_act && hit |=> rx_is_io == $past(bus_data_in[IO_BIT]))
      else $error("I/O half decode wrong");
   a_req_held: assert property (st.tx == TX_ARB && !cyc_en |=> bus_req_out)
      else $error("request dropped while waiting");
   a_lose_wait: assert property (cyc_en && st.tx == TX_ARB && !win |=> st.tx == TX_ARB)
      else $error("lower priority node took the bus");
   a_release_early: assert property (s_addr_word |-> !bus_req_out)
      else $error("request kept while holding");
   a_ctl_parity: assert property (cyc_en && !c_ok |=> par_err)
      else $error("control parity error not flagged");
   a_single_word: assert property (st.tx == TX_DATA0 && cyc_en && !st.dbl |=> st.tx == TX_CONF && !bus_oe)
      else $error("single transfer drove a second word");
   a_confirm_word: assert property (cyc_en && bus_tag_in == TAG_ADDR && !st.rx_act && hit |=> bus_cnf_oe [*8])
      else $error("received word not confirmed");
   a_proto_flag: assert property (cyc_en && bus_tag_in == TAG_DATA && !st.prev_hold |=> proto_err)
      else $error("stray data cycle not flagged");
   a_send_ends: assert property (s_launch |-> ##[75:101] xfer_done)
      else $error("send did not finish");

endmodule : bpa_node
`default_nettype wire

// *** bench/bpa_partner.sv ***
// Far-side bus model: sends queued words to the node and confirms the node's sends.
// Assumes the node ends a bus cycle on every 25th clock after reset release.
`timescale 1ns/1ps
`default_nettype none
module bpa_partner import bpa_pkg::*; (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic sys_rst,
   // Node's own drive.
   input wire logic [1:0] n_tag,
   input wire logic n_oe,
   // Far-side lines.
   output logic cend,
   output logic [31:0] p_data,
   output logic p_par,
   output logic p_ctl,
   output logic [1:0] p_tag,
   output logic p_hold,
   output logic [1:0] p_cnf
);
   logic [4:0] cnt; // Clock within the bus cycle.
   logic adv; // High for the clock after a cycle end.
   logic ours; // The node drove a word in the ended cycle.
   logic [1:0] widx; // Word index of that word.
   logic [36:0] e; // Entry: ctl bad, data bad, hold, tag, data.
   int nak_at = 9; // Word index that gets refused.
   logic [36:0] q[$]; // Words waiting to be sent.
   assign cend = (cnt == 5'h18);
   // Tracks the bus cycle and what the node drove in it.
   always @(posedge core_clk) begin
      cnt <= (sys_rst || cend) ? 5'h0 : cnt + 5'h1;
      adv <= cend && !sys_rst;
      if (cend) begin
         ours <= n_oe && (n_tag != TAG_IDLE);
         widx <= (n_tag == TAG_ADDR) ? 2'h0 : widx + 2'h1;
      end
   end
   // Changes lines half a clock after each cycle end; idle data flips every cycle.
   always @(negedge core_clk) begin
      if (sys_rst) begin
         {p_ctl, p_par, p_hold, p_tag, p_data, p_cnf} <= '0;
      end else if (adv) begin
         p_cnf <= !ours ? CNF_NONE : (widx == nak_at) ? CNF_NAK : CNF_ACK;
         e = (q.size() != 0) ? q.pop_front() : {5'h0, ~p_data};
         {p_hold, p_tag, p_data} <= e[34:0];
         p_par <= (^e[31:0]) ^ e[35];
         p_ctl <= (^e[34:32]) ^ e[36];
      end
   end
endmodule : bpa_partner
`default_nettype wire

// *** bench/bpa_node_tb.sv ***
// Self-checking bench for the bus node beside a far-side model.
// Assumes the node's defaults: request line 3, receive window 3F000000.
`timescale 1ns/1ps
`default_nettype none
module bpa_node_tb import bpa_pkg::*;;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic req_valid = 1'b0;
   logic req_double = 1'b0;
   logic [29:0] req_addr = '0;
   logic [31:0] req_data0 = '0;
   logic [31:0] req_data1 = '0;
   logic [15:0] other_req = '0; // Request lines of the other nodes.
   logic hist_freeze = 1'b0;
   logic [3:0] hist_idx = '0;
   logic req_ready, xfer_done, xfer_error, rx_valid, rx_is_io, bus_req_out, bus_par_out, bus_hold_out, err;
   logic bus_ctl_par_out, bus_oe, bus_cnf_oe, par_err, proto_err, hist_full, cend, p_par, p_ctl, p_hold;
   logic [29:0] rx_addr;
   logic [31:0] rx_data, bus_data_out, p_data, rxq[$];
   logic [1:0] bus_tag_out, bus_cnf_out, p_tag, p_cnf, cnfq[$];
   logic [37:0] hist_entry;
   logic [34:0] seen[$]; // Node's words at cycle ends: tag, hold, data.
   int failures = 0, comparisons = 0, perr = 0, prot = 0;
   bpa_node uut (.core_clk(core_clk), .sys_rst(sys_rst), .req_valid(req_valid), .req_double(req_double),
      .req_addr(req_addr), .req_data0(req_data0), .req_data1(req_data1), .req_ready(req_ready),
      .xfer_done(xfer_done), .xfer_error(xfer_error), .rx_valid(rx_valid), .rx_addr(rx_addr),
      .rx_data(rx_data), .rx_is_io(rx_is_io), .bus_req_in(other_req | ({15'h0, bus_req_out} << 3)),
      .bus_req_out(bus_req_out), .bus_data_in(bus_oe ? bus_data_out : p_data),
      .bus_par_in(bus_oe ? bus_par_out : p_par), .bus_tag_in(bus_oe ? bus_tag_out : p_tag),
      .bus_hold_in(bus_oe ? bus_hold_out : p_hold), .bus_ctl_par_in(bus_oe ? bus_ctl_par_out : p_ctl),
      .bus_data_out(bus_data_out), .bus_par_out(bus_par_out), .bus_tag_out(bus_tag_out),
      .bus_hold_out(bus_hold_out), .bus_ctl_par_out(bus_ctl_par_out), .bus_oe(bus_oe),
      .bus_cnf_in(bus_cnf_oe ? bus_cnf_out : p_cnf), .bus_cnf_out(bus_cnf_out), .bus_cnf_oe(bus_cnf_oe),
      .par_err(par_err), .proto_err(proto_err), .hist_freeze(hist_freeze), .hist_idx(hist_idx),
      .hist_entry(hist_entry), .hist_full(hist_full));
   bpa_partner far (.core_clk(core_clk), .sys_rst(sys_rst), .n_tag(bus_tag_out), .n_oe(bus_oe), .cend(cend),
      .p_data(p_data), .p_par(p_par), .p_ctl(p_ctl), .p_tag(p_tag), .p_hold(p_hold), .p_cnf(p_cnf));
   // Clock of 8 ns.
   initial begin
      forever #4 core_clk = ~core_clk;
   end
   // Records the node's words, confirmations, received data and error pulses.
   always @(posedge core_clk) begin
      if (cend && bus_oe) seen.push_back({bus_tag_out, bus_hold_out, bus_data_out});
      if (cend && bus_cnf_oe) cnfq.push_back(bus_cnf_out);
      if (rx_valid === 1'b1) rxq.push_back(rx_data);
      perr += (par_err === 1'b1);
      prot += (proto_err === 1'b1);
   end
   // Compares one value and counts it.
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   // Lets n cycle ends pass, returning mid-cycle.
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk iff cend);
      repeat (2) @(negedge core_clk);
   endtask : cyc
   // Sends one transfer; a higher line competes for hn cycles first.
   task automatic send(input logic dbl, input logic [29:0] a, input logic [31:0] d0, input logic [31:0] d1,
      input int hn);
      @(negedge core_clk);
      {req_valid, req_double, req_addr, req_data0, req_data1} = {1'b1, dbl, a, d0, d1};
      @(negedge core_clk);
      req_valid = 1'b0;
      if (hn != 0) begin
         cyc(hn);
         chk(bus_req_out, 1'b1);
         chk(seen.size(), 0);
         other_req = '0;
      end
      for (int i = 0; i < 400 && xfer_done !== 1'b1; i++) @(negedge core_clk);
      chk(xfer_done, 1'b1);
      err = xfer_error;
   endtask : send
   // Single word after losing three arbitrations.
   task automatic t_single();
      seen.delete();
      other_req = 16'h0001;
      send(1'b0, 30'h0000_1234, 32'hA5A5_0F0F, 32'h0, 3);
      chk(err, 1'b0);
      chk(seen.size(), 2);
      chk(seen[0], {TAG_ADDR, 1'b1, 32'h4000_1234});
      chk(seen[1], {TAG_DATA, 1'b0, 32'hA5A5_0F0F});
      cyc(1);
      chk({bus_oe, bus_req_out}, 2'b00);
   endtask : t_single
   // Double word whose second word is refused.
   task automatic t_double();
      seen.delete();
      far.nak_at = 2;
      send(1'b1, 30'h0000_2000, 32'h0123_4567, 32'h89AB_CDEF, 0);
      far.nak_at = 9;
      chk(err, 1'b1);
      chk(seen.size(), 3);
      chk(seen[0], {TAG_ADDR, 1'b1, 32'hC000_2000});
      chk(seen[1], {TAG_DATA, 1'b1, 32'h0123_4567});
      chk(seen[2], {TAG_DATA, 1'b0, 32'h89AB_CDEF});
      chk({perr, prot}, 64'h0);
   endtask : t_double
   // Receives a double write whose second word has bad parity.
   task automatic t_receive();
      {perr, prot} = '0;
      cnfq.delete();
      rxq.delete();
      far.q.push_back({2'b00, 1'b1, TAG_ADDR, 32'hFF00_0010});
      far.q.push_back({2'b00, 1'b1, TAG_DATA, 32'h1111_2222});
      far.q.push_back({2'b01, 1'b0, TAG_DATA, 32'h3333_4444});
      cyc(5);
      chk(rxq[0], 32'h1111_2222);
      chk({rx_addr, rx_is_io}, {30'h3F00_0010, 1'b1});
      chk(cnfq.size(), 3);
      chk({cnfq[0], cnfq[1], cnfq[2]}, {CNF_ACK, CNF_ACK, CNF_NAK});
      chk(perr, 1);
      chk(prot, 0);
   endtask : t_receive
   // Hold on an idle cycle, the idle after it, then bad control parity.
   task automatic t_errors();
      {perr, prot} = '0;
      far.q.push_back({2'b00, 1'b1, TAG_IDLE, 32'h0});
      far.q.push_back({2'b00, 1'b0, TAG_IDLE, 32'h0});
      far.q.push_back({2'b10, 1'b0, TAG_IDLE, 32'h0});
      cyc(5);
      chk(prot, 2);
      chk(perr, 1);
   endtask : t_errors
   // Newest history entry stays put while frozen.
   task automatic t_history();
      far.q.push_back({2'b00, 1'b0, TAG_ADDR, 32'h4000_0040});
      cyc(2);
      hist_freeze = 1'b1;
      hist_idx = 4'h0;
      cyc(1);
      chk(hist_entry, {1'b0, CNF_NONE, 1'b0, TAG_ADDR, 32'h4000_0040});
      chk(hist_full, 1'b1);
      hist_freeze = 1'b0;
   endtask : t_history
   // Prints the counts and the verdict, then stops.
   task automatic summarize();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   // Main sequence after three reset clocks.
   initial begin
      repeat (3) @(negedge core_clk);
      sys_rst = 1'b0;
      chk(req_ready, 1'b1);
      t_single();
      t_double();
      t_receive();
      t_errors();
      t_history();
      summarize();
   end
   // Watchdog well past the expected run of about 26 bus cycles.
   initial begin
      #100000;
      failures++;
      summarize();
   end
endmodule : bpa_node_tb
`default_nettype wire
